// >>> design/pfp_pkg.sv
// package: register map, field layout and reset values of the clock and power control block
package pfp_pkg;

    // ************************************************************
    // register map (byte addresses on the peripheral bus)
    // ************************************************************
    localparam logic [31:0] PLL_CONTROL_HOLD_ADDR = 32'hE01FC080; // enable/connect hold
    localparam logic [31:0] PLL_SETTING_HOLD_ADDR = 32'hE01FC084; // multiplier/divider hold
    localparam logic [31:0] PLL_STATUS_ADDR       = 32'hE01FC088; // active values and lock
    localparam logic [31:0] PLL_UPDATE_KEY_ADDR   = 32'hE01FC08C; // unlock key port
    localparam logic [31:0] POWER_MODE_ADDR       = 32'hE01FC0C0; // power mode control
    localparam logic [31:0] PERIPH_GATE_ADDR      = 32'hE01FC0C4; // peripheral clock gate

    // ************************************************************
    // unlock keys
    // ************************************************************
    localparam logic [7:0] KEY_FIRST  = 8'hAA;
    localparam logic [7:0] KEY_SECOND = 8'h55;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int PLL_ON_POS      = 0;  // pll_on_bit in control hold
    localparam int PLL_LINK_POS    = 1;  // pll_link_bit in control hold
    localparam int MULT_LSB        = 0;  // multiplier_field 4:0
    localparam int DIV_LSB         = 5;  // divider_field 6:5
    localparam int STAT_ON_POS     = 8;  // active enable read-back
    localparam int STAT_LINK_POS   = 9;  // active connect read-back
    localparam int STAT_LOCK_POS   = 10; // lock_flag
    localparam int SLEEP_POS       = 0;  // sleep_bit
    localparam int DEEP_SLEEP_POS  = 1;  // deep_sleep_bit
    localparam int BROWNOUT_POS    = 2;  // brownout_off_bit, active low sense

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [1:0]  PLL_CONTROL_RESET = 2'h0;
    localparam logic [6:0]  PLL_SETTING_RESET = 7'h00;
    localparam logic [2:0]  POWER_MODE_RESET  = 3'h0;
    localparam logic [31:0] PERIPH_GATE_RESET = 32'h001817BE;

    // ************************************************************
    // carriers
    // ************************************************************
    // one peripheral bus access
    typedef struct packed {
        logic        sel;   // access strobe, one cycle
        logic        write; // 1 write, 0 read
        logic [31:0] addr;  // byte address
        logic [31:0] wdata; // write data
    } pfp_bus_req_t;

    // active pll settings as they leave the block
    typedef struct packed {
        logic       on;   // pll running
        logic       link; // pll is clock source
        logic [5:0] mult; // M, 1..32
        logic [3:0] div;  // P, 1/2/4/8
    } pfp_pll_drive_t;

    // unlock detector states
    typedef enum logic [0:0] {
        UNLOCK_IDLE  = 1'b0,
        UNLOCK_ARMED = 1'b1
    } pfp_unlock_state_t;

endpackage

// >>> design/pfp_clock_power.sv
// module: pll unlock, power modes and peripheral clock gating
//
// Summary of operation
// - key writes must be consecutive bus cycles
// - bad key, order or gap leaves settings unchanged
// - deep sleep entry turns pll off, disconnects
// - wakeup never restores pll state by itself
// - core clock M times osc; cco times 2P
// - multiplier field plus one gives M
// - divider field 00,01,10,11 gives 1,2,4,8
// - sleep bit stops cpu clock until interrupt
// - deep sleep stops clocks; external interrupt wakes
// - both bits set means deep sleep
// - deep sleep ends on reset or clockless interrupt
// - deep sleep keeps state and pins static
// - wakeup resumes without lost or repeated instruction
// - brownout off bit only matters during deep sleep
// - one gate bit per peripheral; core never gated
// - gate bit index equals peripheral number
// - enable and connect act after unlock only
// - lock flag in status bit 10 and to interrupts
// - deep sleep clears enable/connect read-backs
`timescale 1ns/1ps

module pfp_clock_power #(
    parameter int GATE_W = 32 // width of the peripheral gate register
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire pfp_pkg::pfp_bus_req_t bus_req,
    output logic [31:0]                bus_rdata,
    input  wire logic                  pll_lock,
    input  wire logic                  wake_irq,
    input  wire logic                  wake_ext_irq,
    input  wire logic                  instr_boundary,
    output pfp_pkg::pfp_pll_drive_t    pll_drive,
    output logic                       lock_irq,
    output logic                       cpu_clk_en,
    output logic                       osc_run,
    output logic                       clocks_run,
    output logic                       pins_hold,
    output logic                       brownout_active,
    output logic [GATE_W-1:0]          periph_clk_en
);

    // ************************************************************
    // helper functions
    // ************************************************************

    // M = field + 1, widened so 11111 gives 32
    function automatic logic [5:0] mult_of(input logic [4:0] field);
        mult_of = {1'b0, field} + 6'h01;
    endfunction

    // P is a power of two chosen by the two-bit field
    function automatic logic [3:0] div_of(input logic [1:0] field);
        div_of = 4'h1 << field;
    endfunction

    // ************************************************************
    // bus decode
    // ************************************************************
    wire wr_en      = bus_req.sel & bus_req.write;   // any write cycle
    wire wr_ctrl    = wr_en & (bus_req.addr == pfp_pkg::PLL_CONTROL_HOLD_ADDR);
    wire wr_set     = wr_en & (bus_req.addr == pfp_pkg::PLL_SETTING_HOLD_ADDR);
    wire wr_key     = wr_en & (bus_req.addr == pfp_pkg::PLL_UPDATE_KEY_ADDR);
    wire wr_pmode   = wr_en & (bus_req.addr == pfp_pkg::POWER_MODE_ADDR);
    wire wr_gate    = wr_en & (bus_req.addr == pfp_pkg::PERIPH_GATE_ADDR);
    wire key_first  = wr_key & (bus_req.wdata[7:0] == pfp_pkg::KEY_FIRST);
    wire key_second = wr_key & (bus_req.wdata[7:0] == pfp_pkg::KEY_SECOND);

    // ************************************************************
    // holding registers and active shadows
    // ************************************************************
    logic [1:0]        pll_control_hold;   // written enable/connect, not yet applied
    logic [6:0]        pll_setting_hold;   // written divider/multiplier, not yet applied
    logic [1:0]        ctrl_active;        // enable/connect in effect
    logic [6:0]        set_active;         // divider/multiplier in effect
    logic [2:0]        power_mode_reg;     // brownout, deep sleep, sleep
    logic [GATE_W-1:0] peripheral_gate_reg; // one bit per peripheral
    logic              cpu_halted;         // sleep in progress

    pfp_pkg::pfp_unlock_state_t unlock_state;      // key detector
    pfp_pkg::pfp_unlock_state_t next_unlock_state;

    // ************************************************************
    // unlock detector
    // ************************************************************
    // the armed state lives only one cycle, so any other bus cycle,
    // an idle cycle included, breaks the pair
    always_comb begin
        unlock_state_next_default: begin
            next_unlock_state = pfp_pkg::UNLOCK_IDLE;
        end
        unique case (unlock_state)
            pfp_pkg::UNLOCK_IDLE: begin
                if (key_first) begin
                    next_unlock_state = pfp_pkg::UNLOCK_ARMED;
                end
            end
            pfp_pkg::UNLOCK_ARMED: begin
                // a new first key re-arms; anything else drops back
                if (key_first) begin
                    next_unlock_state = pfp_pkg::UNLOCK_ARMED;
                end
            end
        endcase
    end

    // commit strobe: second key right after first key
    wire commit = (unlock_state == pfp_pkg::UNLOCK_ARMED) & key_second;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            unlock_state <= pfp_pkg::UNLOCK_IDLE;
        end else begin
            unlock_state <= next_unlock_state;
        end
    end

    // ************************************************************
    // power mode decode
    // ************************************************************
    wire pmode_sleep   = bus_req.wdata[pfp_pkg::SLEEP_POS];
    wire pmode_deep    = bus_req.wdata[pfp_pkg::DEEP_SLEEP_POS];
    // deep sleep wins over sleep when both are written
    wire enter_deep    = wr_pmode & pmode_deep;
    wire enter_sleep   = wr_pmode & pmode_sleep & ~pmode_deep;
    wire deep_now      = power_mode_reg[pfp_pkg::DEEP_SLEEP_POS];
    // only an interrupt that works without clocks ends deep sleep
    wire deep_wake     = deep_now & wake_ext_irq;

    // ************************************************************
    // pll control and setting holds
    // ************************************************************
    // holds take writes at any time; they steer nothing until commit
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pll_control_hold <= pfp_pkg::PLL_CONTROL_RESET;
            pll_setting_hold <= pfp_pkg::PLL_SETTING_RESET;
        end else begin
            if (wr_ctrl) begin
                pll_control_hold <= bus_req.wdata[1:0];
            end
            if (wr_set) begin
                pll_setting_hold <= bus_req.wdata[6:0];
            end
        end
    end

    // ************************************************************
    // active pll state
    // ************************************************************
    // deep sleep entry beats a commit in the same cycle; waking does
    // not touch these, so software must re-enable step by step
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_active <= pfp_pkg::PLL_CONTROL_RESET;
            set_active  <= pfp_pkg::PLL_SETTING_RESET;
        end else if (enter_deep) begin
            ctrl_active <= 2'h0;
        end else if (commit) begin
            ctrl_active <= pll_control_hold;
            set_active  <= pll_setting_hold;
        end
    end

    // ************************************************************
    // power mode register and sleep
    // ************************************************************
    // deep sleep bit clears itself on the clockless wake; a write in
    // the wake cycle wins and loads all three bits, so that clear is skipped
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            power_mode_reg <= pfp_pkg::POWER_MODE_RESET;
        end else if (wr_pmode) begin
            power_mode_reg <= bus_req.wdata[2:0];
        end else if (deep_wake) begin
            power_mode_reg[pfp_pkg::DEEP_SLEEP_POS] <= 1'b0;
            power_mode_reg[pfp_pkg::SLEEP_POS]      <= 1'b0;
        end else if (cpu_halted & wake_irq) begin
            power_mode_reg[pfp_pkg::SLEEP_POS] <= 1'b0;
        end
    end

    // cpu clock held off only at an instruction boundary, so the
    // interrupted instruction is neither cut nor repeated
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cpu_halted <= 1'b0;
        end else if (wake_irq | deep_wake) begin
            cpu_halted <= 1'b0;
        end else if (power_mode_reg[pfp_pkg::SLEEP_POS] & ~deep_now & instr_boundary) begin
            cpu_halted <= 1'b1;
        end
    end

    // ************************************************************
    // peripheral clock gate
    // ************************************************************
    // bit n gates peripheral n; core blocks have no bit here at all
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            peripheral_gate_reg <= pfp_pkg::PERIPH_GATE_RESET[GATE_W-1:0];
        end else if (wr_gate) begin
            peripheral_gate_reg <= bus_req.wdata[GATE_W-1:0];
        end
    end

    // ************************************************************
    // read mux
    // ************************************************************
    wire [31:0] stat_word = {21'h000000, pll_lock, ctrl_active[1], ctrl_active[0],
                             1'b0, set_active};
    wire [31:0] gate_word = {{(32 - GATE_W){1'b0}}, peripheral_gate_reg};

    logic [31:0] next_rdata; // selected read value
    always_comb begin
        next_rdata = 32'h00000000; // unmapped and key port read zero
        if (bus_req.sel & ~bus_req.write) begin
            unique case (bus_req.addr)
                pfp_pkg::PLL_CONTROL_HOLD_ADDR: next_rdata = {30'h00000000, pll_control_hold};
                pfp_pkg::PLL_SETTING_HOLD_ADDR: next_rdata = {25'h0000000, pll_setting_hold};
                pfp_pkg::PLL_STATUS_ADDR:       next_rdata = stat_word;
                pfp_pkg::POWER_MODE_ADDR:       next_rdata = {29'h00000000, power_mode_reg};
                pfp_pkg::PERIPH_GATE_ADDR:      next_rdata = gate_word;
                default:                        next_rdata = 32'h00000000;
            endcase
        end
    end

    // read data registered, valid the cycle after the strobe
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bus_rdata <= 32'h00000000;
        end else begin
            bus_rdata <= next_rdata;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // pll connects only when both active bits are one
    assign pll_drive.on   = ctrl_active[0];
    assign pll_drive.link = ctrl_active[0] & ctrl_active[1];
    assign pll_drive.mult = mult_of(set_active[4:0]);
    assign pll_drive.div  = div_of(set_active[6:5]);
    assign lock_irq       = pll_lock;
    assign cpu_clk_en     = ~cpu_halted & ~deep_now;
    assign osc_run        = ~deep_now;
    assign clocks_run     = ~deep_now;
    assign pins_hold      = deep_now;
    // bit set while deep sleeping turns the detector off
    assign brownout_active = ~(deep_now & power_mode_reg[pfp_pkg::BROWNOUT_POS]);
    // gated clocks also stop during deep sleep
    assign periph_clk_en  = peripheral_gate_reg & {GATE_W{~deep_now}};

endmodule

// >>> testbench/pfp_clock_power_properties.sv
// checker: port timing relations of the clock and power control block
`timescale 1ns/1ps

module pfp_clock_power_properties #(
    parameter int GATE_W = 32 // gate register width
) (
    input wire logic                    clk_sys,
    input wire logic                    rst,
    input wire pfp_pkg::pfp_bus_req_t   bus_req,
    input wire logic [31:0]             bus_rdata,
    input wire logic                    pll_lock,
    input wire logic                    wake_irq,
    input wire logic                    wake_ext_irq,
    input wire logic                    instr_boundary,
    input wire pfp_pkg::pfp_pll_drive_t pll_drive,
    input wire logic                    lock_irq,
    input wire logic                    cpu_clk_en,
    input wire logic                    osc_run,
    input wire logic                    clocks_run,
    input wire logic                    pins_hold,
    input wire logic                    brownout_active,
    input wire logic [GATE_W-1:0]       periph_clk_en
);
    // ************************************************************
    // decoded bus events
    // ************************************************************
    logic key_wr; // any write to the key port
    logic key_a;  // first key written
    logic key_b;  // second key written
    logic pd_wr;  // write that enters deep sleep
    logic st_rd;  // status read
    assign key_wr = bus_req.sel && bus_req.write && bus_req.addr == pfp_pkg::PLL_UPDATE_KEY_ADDR;
    assign key_a  = key_wr && bus_req.wdata[7:0] == pfp_pkg::KEY_FIRST;
    assign key_b  = key_wr && bus_req.wdata[7:0] == pfp_pkg::KEY_SECOND;
    assign pd_wr  = bus_req.sel && bus_req.write && bus_req.addr == pfp_pkg::POWER_MODE_ADDR
                    && bus_req.wdata[1];
    assign st_rd  = bus_req.sel && !bus_req.write && bus_req.addr == pfp_pkg::PLL_STATUS_ADDR;

    // ************************************************************
    // properties, all in the system clock domain
    // ************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_hold_steady_pll: assert property (!(key_b && $past(key_a)) |=>
        $stable(pll_drive.mult) && $stable(pll_drive.div)) else $error("pll moved without unlock");
    a_sleep_drops_pll: assert property (pd_wr |=> !pll_drive.on && !pll_drive.link
        && !osc_run && !clocks_run && pins_hold) else $error("deep sleep entry incomplete");
    a_ext_wake_only: assert property (pins_hold && wake_ext_irq && !pd_wr && !key_wr |=>
        !pins_hold && osc_run && !pll_drive.on) else $error("external wake wrong");
    a_lock_irq_mirror: assert property (lock_irq == pll_lock) else $error("lock irq differs");
    a_link_needs_on: assert property (pll_drive.link |-> pll_drive.on) else $error("link w/o on");
    a_field_encode: assert property ($onehot(pll_drive.div) && pll_drive.mult != 6'h00
        && pll_drive.mult <= 6'h20) else $error("multiplier or divider out of range");
    a_status_read: assert property (st_rd |=> bus_rdata[10] == $past(pll_lock)
        && bus_rdata[8] == $past(pll_drive.on)
        && (bus_rdata[9] & bus_rdata[8]) == $past(pll_drive.link)) else $error("status bad");
    a_sleep_gates_all: assert property (pins_hold |-> periph_clk_en == '0 && !clocks_run)
        else $error("clocks run in deep sleep");
    a_brownout_sense: assert property (!brownout_active |-> pins_hold)
        else $error("detector off outside deep sleep");
endmodule

bind pfp_clock_power pfp_clock_power_properties #(.GATE_W(GATE_W)) u_props (
    .clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .pll_lock(pll_lock), .wake_irq(wake_irq), .wake_ext_irq(wake_ext_irq),
    .instr_boundary(instr_boundary), .pll_drive(pll_drive), .lock_irq(lock_irq),
    .cpu_clk_en(cpu_clk_en), .osc_run(osc_run), .clocks_run(clocks_run), .pins_hold(pins_hold),
    .brownout_active(brownout_active), .periph_clk_en(periph_clk_en));

// >>> testbench/testbench.sv
// testbench: directed scenarios for the clock and power control block
`timescale 1ns/1ps

module testbench;
    logic                    clk_sys, rst, pll_lock, wake_irq, wake_ext_irq, instr_boundary;
    pfp_pkg::pfp_bus_req_t   bus_req;    // register bus request
    logic [31:0]             bus_rdata;  // read answer
    pfp_pkg::pfp_pll_drive_t pll_drive;  // active pll values
    logic                    lock_irq, cpu_clk_en, osc_run, clocks_run, pins_hold;
    logic                    brownout_active;
    logic [31:0]             periph_clk_en;
    logic [31:0]             d;          // scratch read value
    int                      err_total, samples_checked;

    pfp_clock_power #(.GATE_W(32)) uut (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .pll_lock(pll_lock), .wake_irq(wake_irq),
        .wake_ext_irq(wake_ext_irq), .instr_boundary(instr_boundary), .pll_drive(pll_drive),
        .lock_irq(lock_irq), .cpu_clk_en(cpu_clk_en), .osc_run(osc_run),
        .clocks_run(clocks_run), .pins_hold(pins_hold), .brownout_active(brownout_active),
        .periph_clk_en(periph_clk_en));

    // ************************************************************
    // bus tasks: request set at falling edge, taken at the next rising
    // ************************************************************
    always #5 clk_sys = ~clk_sys;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(negedge clk_sys);
        bus_req = '{sel: 1'b1, write: 1'b1, addr: a, wdata: v};
    endtask
    task automatic idle();
        @(negedge clk_sys);
        bus_req.sel = 1'b0;
    endtask
    task automatic rd(input logic [31:0] a);
        @(negedge clk_sys);
        bus_req = '{sel: 1'b1, write: 1'b0, addr: a, wdata: 32'h00000000};
        idle();
        d = bus_rdata;
    endtask
    // holds first, then both keys, then one quiet cycle
    task automatic commit(input logic [31:0] c, input logic [31:0] s);
        wr(pfp_pkg::PLL_CONTROL_HOLD_ADDR, c);
        wr(pfp_pkg::PLL_SETTING_HOLD_ADDR, s);
        wr(pfp_pkg::PLL_UPDATE_KEY_ADDR, 32'h000000AA);
        wr(pfp_pkg::PLL_UPDATE_KEY_ADDR, 32'h00000055);
        idle();
    endtask
    // expected pll drive word from on, connect and raw fields
    function automatic logic [31:0] drv(input logic on, input logic cn, input logic [6:0] s);
        return {20'h00000, on, on & cn, 6'(s[4:0]) + 6'h01, 4'h1 << s[6:5]};
    endfunction

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        check({pll_drive}, drv(1'b0, 1'b0, 7'h00));
        check(periph_clk_en, pfp_pkg::PERIPH_GATE_RESET);
        rd(pfp_pkg::PLL_STATUS_ADDR);
        check(d, 32'h00000000);
        rd(pfp_pkg::PLL_UPDATE_KEY_ADDR);
        check(d, 32'h00000000);
        $display("test reset done");
    endtask
    task automatic t_commit();
        for (int i = 0; i < 4; i++) begin
            commit(32'h00000001, {25'h0000000, i[1:0], 5'(i * 10)});
            check({pll_drive}, drv(1'b1, 1'b0, {i[1:0], 5'(i * 10)}));
        end
        pll_lock = 1'b1;
        commit(32'h00000003, 32'h00000025);
        check({pll_drive}, drv(1'b1, 1'b1, 7'h25));
        check({31'h0, lock_irq}, 32'h00000001);
        rd(pfp_pkg::PLL_STATUS_ADDR);
        check(d, 32'h00000725);
        $display("test commit done");
    endtask
    task automatic t_refused();
        wr(pfp_pkg::PLL_SETTING_HOLD_ADDR, 32'h0000007F);
        wr(pfp_pkg::PLL_UPDATE_KEY_ADDR, 32'h000000AA);
        idle();
        wr(pfp_pkg::PLL_UPDATE_KEY_ADDR, 32'h00000055);
        wr(pfp_pkg::PLL_UPDATE_KEY_ADDR, 32'h000000AA);
        rd(pfp_pkg::PERIPH_GATE_ADDR);
        wr(pfp_pkg::PLL_UPDATE_KEY_ADDR, 32'h00000055);
        wr(pfp_pkg::PLL_UPDATE_KEY_ADDR, 32'h000000AA);
        wr(pfp_pkg::PLL_UPDATE_KEY_ADDR, 32'h00000056);
        idle();
        check({pll_drive}, drv(1'b1, 1'b1, 7'h25));
        wr(pfp_pkg::PLL_UPDATE_KEY_ADDR, 32'h000000AA);
        commit(32'h00000003, 32'h0000007F);
        check({pll_drive}, drv(1'b1, 1'b1, 7'h7F));
        $display("test refused done");
    endtask
    task automatic t_sleep();
        wr(pfp_pkg::POWER_MODE_ADDR, 32'h00000003);
        idle();
        check({osc_run, clocks_run, pins_hold, brownout_active, pll_drive.on, pll_drive.link},
              6'b001100);
        check(periph_clk_en, 32'h00000000);
        wake_irq = 1'b1;
        repeat (3) @(negedge clk_sys);
        wake_irq = 1'b0;
        check({31'h0, pins_hold}, 32'h00000001);
        wake_ext_irq = 1'b1;
        @(negedge clk_sys);
        wake_ext_irq = 1'b0;
        check({osc_run, clocks_run, pins_hold, pll_drive.on}, 4'b1100);
        rd(pfp_pkg::PLL_STATUS_ADDR);
        check(d[9:8], 2'b00);
        rd(pfp_pkg::POWER_MODE_ADDR);
        check(d[1], 1'b0);
        // restart after wake: enable, see lock, only then connect
        commit(32'h00000001, 32'h00000025);
        check({pll_drive}, drv(1'b1, 1'b0, 7'h25));
        check({31'h0, lock_irq}, 32'h00000001);
        commit(32'h00000003, 32'h00000025);
        check({pll_drive}, drv(1'b1, 1'b1, 7'h25));
        wr(pfp_pkg::POWER_MODE_ADDR, 32'h00000006);
        idle();
        check({31'h0, brownout_active}, 32'h00000000);
        wake_ext_irq = 1'b1;
        wr(pfp_pkg::POWER_MODE_ADDR, 32'h00000004);
        wake_ext_irq = 1'b0;
        idle();
        check({brownout_active, pins_hold}, 2'b10);
        check(periph_clk_en, pfp_pkg::PERIPH_GATE_RESET);
        $display("test deep sleep done");
    endtask
    task automatic t_idle_gate();
        wr(pfp_pkg::POWER_MODE_ADDR, 32'h00000001);
        idle();
        repeat (2) @(negedge clk_sys);
        check({30'h0, cpu_clk_en, osc_run}, 32'h00000001);
        check(periph_clk_en, pfp_pkg::PERIPH_GATE_RESET);
        wake_irq = 1'b1;
        @(negedge clk_sys);
        wake_irq = 1'b0;
        @(negedge clk_sys);
        check({31'h0, cpu_clk_en}, 32'h00000001);
        wr(pfp_pkg::PERIPH_GATE_ADDR, 32'h00080003);
        rd(pfp_pkg::PERIPH_GATE_ADDR);
        check(d, 32'h00080003);
        check(periph_clk_en, 32'h00080003);
        rd(32'hE01FC0C8);
        check(d, 32'h00000000);
        $display("test idle and gate done");
    endtask

    // ************************************************************
    // run control
    // ************************************************************
    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // watchdog: the scenarios need well under 2000 cycles
    initial begin
        #100us;
        err_total++;
        results();
    end
    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        bus_req = '0;
        {pll_lock, wake_irq, wake_ext_irq} = 3'b000;
        instr_boundary = 1'b1;
        err_total = 0;
        samples_checked = 0;
        repeat (12) @(negedge clk_sys);
        rst = 1'b0;
        t_reset();
        t_commit();
        t_refused();
        t_sleep();
        t_idle_gate();
        results();
    end
endmodule
